// file: common/indexer_pkg.sv
package indexer_pkg;

  localparam int unsigned TABLE_ENTRIES  = 8;
  localparam int unsigned TABLE_IDX_W    = 3;
  localparam int unsigned SPEED_W        = 16;
  localparam int unsigned TC_W           = 15;
  localparam int unsigned STATION_W      = 8;
  localparam int unsigned TORQUE_W       = 16;
  localparam int unsigned DELAY_W        = 16;
  localparam int unsigned DIGIT_W        = 4;

  localparam logic [TC_W-1:0] TC_MAX_MS   = 15'h4E20;
  localparam logic [TC_W-1:0] TC_RESET_MS = 15'h0000;
  localparam logic [SPEED_W-1:0] SPEED_RESET = 16'h0000;

  localparam logic [DIGIT_W-1:0] OPSEL_INDEXER    = 4'h1;
  localparam logic [DIGIT_W-1:0] SPEED_SRC_TABLE  = 4'h0;
  localparam logic [DIGIT_W-1:0] SPEED_SRC_DIRECT = 4'h1;

  localparam logic [TABLE_IDX_W-1:0] RAMP_ENTRY_DIRECT = 3'h0;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned NS_PER_MS     = 1000000;
  localparam int unsigned MS_CYCLES     = (NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MOVE = 2'b01,
    ST_HOLD = 2'b10,
    ST_DONE = 2'b11
  } move_state_e;

endpackage : indexer_pkg

// file: common/table_if.sv
`timescale 1ns/100ps
interface table_if;
  import indexer_pkg::*;

  logic                   wr_en;
  logic [TABLE_IDX_W-1:0] wr_idx;
  logic [SPEED_W-1:0]     wr_speed;
  logic [TC_W-1:0]        wr_accel;
  logic [TC_W-1:0]        wr_decel;
  logic [TABLE_IDX_W-1:0] rd_idx;
  logic [SPEED_W-1:0]     rd_speed;
  logic [TC_W-1:0]        rd_accel;
  logic [TC_W-1:0]        rd_decel;

  modport owner (input wr_en, wr_idx, wr_speed, wr_accel, wr_decel, rd_idx,
                 output rd_speed, rd_accel, rd_decel);
  modport user  (output wr_en, wr_idx, wr_speed, wr_accel, wr_decel, rd_idx,
                 input rd_speed, rd_accel, rd_decel);
endinterface : table_if

// file: rtl/point_table.sv
`timescale 1ns/100ps
module point_table (
  input wire logic clk,
  input wire logic rst_n,
  table_if.owner   tbl
);
  import indexer_pkg::*;

  typedef struct packed {
    logic [TABLE_ENTRIES-1:0][SPEED_W-1:0] speed;
    logic [TABLE_ENTRIES-1:0][TC_W-1:0]    accel;
    logic [TABLE_ENTRIES-1:0][TC_W-1:0]    decel;
  } table_s;

  table_s state_reg;
  table_s state_next;

  // Ramp constants above the legal range are held at the maximum rather than wrapped.
  function automatic logic [TC_W-1:0] sat_tc(input logic [TC_W-1:0] v);
    sat_tc = (v > TC_MAX_MS) ? TC_MAX_MS : v;
  endfunction : sat_tc

  always_comb begin
    state_next = state_reg;
    if (tbl.wr_en) begin
      state_next.speed[tbl.wr_idx] = tbl.wr_speed; // [RULE_01]
      state_next.accel[tbl.wr_idx] = sat_tc(tbl.wr_accel); // [RULE_02]
      state_next.decel[tbl.wr_idx] = sat_tc(tbl.wr_decel); // [RULE_03]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tbl.rd_speed = state_reg.speed[tbl.rd_idx];
  assign tbl.rd_accel = state_reg.accel[tbl.rd_idx];
  assign tbl.rd_decel = state_reg.decel[tbl.rd_idx];

endmodule : point_table

// file: rtl/indexer_station_positioning.sv
`timescale 1ns/100ps
// Behaviour
// RULE_01 - Eight-entry table of speed and ramps
// RULE_02 - Acceleration constant 0 to 20000 ms
// RULE_03 - Deceleration constant 0 to 20000 ms
// RULE_04 - Master keeps table speeds within motor limit
// RULE_05 - Direct speed needs two stations, ramps entry1
// RULE_06 - Table mode moves with indexed entry
// RULE_07 - Direct mode uses speed word, entry1 ramps
// RULE_08 - Start without home raises alarm, no move
// RULE_09 - Station beyond count minus one warns
// RULE_10 - Start ignored while a move runs
// RULE_11 - Master restarts only after move complete
// RULE_12 - Stop torque limit after delay past in-position
// RULE_13 - At power-on report in-position from position
// RULE_14 - Master updates words before raising start
// RULE_15 - Shortest mode picks shortest rotation direction
// RULE_16 - Shortest mode without registers uses discrete bits
// RULE_17 - Shortest mode needs indexer digit, both selects
// RULE_18 - Station count used, direction parameter ignored; code ignores the direction parameter only in shortest mode
// RULE_19 - Speed-source digit picks table or direct speed
// RULE_20 - Words latched at start, held during move
module indexer_station_positioning #(
  parameter int unsigned MS_CYCLES_P = indexer_pkg::MS_CYCLES
) (
  input  wire logic                               clk,
  input  wire logic                               rst_n,
  input  wire logic                               table_wr_en,
  input  wire logic [indexer_pkg::TABLE_IDX_W-1:0] table_wr_idx,
  input  wire logic [indexer_pkg::SPEED_W-1:0]     table_wr_speed,
  input  wire logic [indexer_pkg::TC_W-1:0]        table_wr_accel,
  input  wire logic [indexer_pkg::TC_W-1:0]        table_wr_decel,
  input  wire logic [indexer_pkg::DIGIT_W-1:0]     operation_select_param,
  input  wire logic [indexer_pkg::DIGIT_W-1:0]     speed_source_param,
  input  wire logic [indexer_pkg::STATION_W-1:0]   station_count_param,
  input  wire logic                               station_direction_param,
  input  wire logic [indexer_pkg::TORQUE_W-1:0]    stop_torque_limit_param,
  input  wire logic [indexer_pkg::DELAY_W-1:0]     torque_switch_delay_param,
  input  wire logic [indexer_pkg::TORQUE_W-1:0]    run_torque_limit,
  input  wire logic                               two_station_mode,
  input  wire logic                               opmode_sel_a,
  input  wire logic                               opmode_sel_b,
  input  wire logic                               position_speed_spec_sel,
  input  wire logic                               start_cmd,
  input  wire logic                               rotation_dir_cmd,
  input  wire logic [indexer_pkg::STATION_W-1:0]   target_station_word,
  input  wire logic [indexer_pkg::SPEED_W-1:0]     speed_or_table_word,
  input  wire logic [indexer_pkg::STATION_W-1:0]   station_sel_bits,
  input  wire logic [indexer_pkg::TABLE_IDX_W-1:0] speed_sel_bits,
  input  wire logic                               home_done,
  input  wire logic                               alarm_clear,
  input  wire logic                               pos_in_range,
  input  wire logic [indexer_pkg::STATION_W-1:0]   current_station,
  input  wire logic                               motion_done,
  output logic                                    in_position,
  output logic                                    move_complete,
  output logic                                    home_missing_alarm,
  output logic                                    station_range_warning,
  output logic [indexer_pkg::TORQUE_W-1:0]         torque_limit,
  output logic                                    move_req,
  output logic [indexer_pkg::STATION_W-1:0]        move_station,
  output logic [indexer_pkg::SPEED_W-1:0]          move_speed,
  output logic [indexer_pkg::TC_W-1:0]             move_accel,
  output logic [indexer_pkg::TC_W-1:0]             move_decel,
  output logic                                    move_dir_fwd
);
  import indexer_pkg::*;

  localparam int unsigned PRE_W = $clog2(MS_CYCLES_P + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYCLES_P - 1);

  generate
    if (MS_CYCLES_P < 1) begin : g_bad_ms
      $error("MS_CYCLES_P must be at least one cycle");
    end
  endgenerate

  typedef struct packed {
    move_state_e           st;
    logic                  start_prev;
    logic                  in_pos;
    logic                  complete;
    logic                  home_alarm;
    logic                  range_warn;
    logic [TORQUE_W-1:0]   torque;
    logic [PRE_W-1:0]      prescale;
    logic [DELAY_W-1:0]    ms_cnt;
    logic                  req;
    logic [STATION_W-1:0]  station;
    logic [SPEED_W-1:0]    speed;
    logic [TC_W-1:0]       accel;
    logic [TC_W-1:0]       decel;
    logic                  dir_fwd;
  } ctrl_s;

  ctrl_s state_reg;
  ctrl_s state_next;

  table_if tbl ();

  point_table u_table (
    .clk   (clk),
    .rst_n (rst_n),
    .tbl   (tbl)
  );

  // True when going up from cur to tgt is no longer than going down, on a ring of n stations.
  function automatic logic shortest_fwd(input logic [STATION_W-1:0] tgt,
                                        input logic [STATION_W-1:0] cur,
                                        input logic [STATION_W-1:0] n);
    logic [STATION_W:0] diff;
    diff = '0;
    if (tgt >= cur) begin
      diff = {1'b0, tgt} - {1'b0, cur};
    end else begin
      diff = {1'b0, tgt} + {1'b0, n} - {1'b0, cur};
    end
    shortest_fwd = ({diff, 1'b0} <= {1'b0, 1'b0, n});
  endfunction : shortest_fwd

  logic                   indexer_on;
  logic                   shortest_mode;
  logic                   use_register;
  logic                   direct_speed;
  logic [STATION_W-1:0]   sel_station;
  logic [TABLE_IDX_W-1:0] sel_entry;
  logic                   start_edge;
  logic                   out_of_range;

  always_comb begin
    indexer_on    = (operation_select_param == OPSEL_INDEXER);
    shortest_mode = indexer_on && opmode_sel_a && opmode_sel_b; // [RULE_17]
    use_register  = position_speed_spec_sel && !shortest_mode;
    // A single occupied station has no speed word, so direct speed is refused there.
    direct_speed  = use_register && two_station_mode &&
                    (speed_source_param == SPEED_SRC_DIRECT); // [RULE_05] [RULE_19]
    sel_station   = use_register ? target_station_word : station_sel_bits; // [RULE_16]
    if (direct_speed) begin
      sel_entry = RAMP_ENTRY_DIRECT; // [RULE_07]
    end else if (!two_station_mode) begin
      sel_entry = RAMP_ENTRY_DIRECT;
    end else if (use_register) begin
      sel_entry = speed_or_table_word[TABLE_IDX_W-1:0]; // [RULE_06]
    end else begin
      sel_entry = speed_sel_bits;
    end
    start_edge   = start_cmd && !state_reg.start_prev;
    out_of_range = (sel_station >= station_count_param); // [RULE_09] [RULE_18]
  end

  always_comb begin
    tbl.wr_en    = table_wr_en;
    tbl.wr_idx   = table_wr_idx;
    tbl.wr_speed = table_wr_speed;
    tbl.wr_accel = table_wr_accel;
    tbl.wr_decel = table_wr_decel;
    tbl.rd_idx   = sel_entry;
  end

  always_comb begin
    state_next            = state_reg;
    state_next.start_prev = start_cmd;
    state_next.req        = 1'b0;
    state_next.range_warn = indexer_on && out_of_range; // [RULE_09]
    // A clear in the same cycle as a refused start loses to the new alarm.
    if (alarm_clear) begin
      state_next.home_alarm = 1'b0;
    end
    case (state_reg.st)
      ST_IDLE, ST_DONE: begin
        if (state_reg.st == ST_IDLE) begin
          state_next.in_pos = pos_in_range; // [RULE_13]
        end
        if (indexer_on && start_edge) begin
          if (!home_done) begin
            state_next.home_alarm = 1'b1; // [RULE_08]
          end else if (!out_of_range) begin
            state_next.st       = ST_MOVE;
            state_next.req      = 1'b1;
            state_next.in_pos   = 1'b0;
            state_next.complete = 1'b0;
            state_next.torque   = run_torque_limit;
            state_next.station  = sel_station; // [RULE_20]
            state_next.speed    = direct_speed ? speed_or_table_word : tbl.rd_speed; // [RULE_06] [RULE_07]
            state_next.accel    = tbl.rd_accel;
            state_next.decel    = tbl.rd_decel;
            if (shortest_mode) begin
              state_next.dir_fwd = shortest_fwd(sel_station, current_station,
                                                station_count_param); // [RULE_15] [RULE_18]
            end else begin
              state_next.dir_fwd = rotation_dir_cmd ^ station_direction_param;
            end
          end
        end
      end
      ST_MOVE: begin
        // Starts are not looked at here, so a start during the move has no effect.
        if (motion_done) begin // [RULE_10]
          state_next.st       = ST_HOLD;
          state_next.in_pos   = 1'b1;
          state_next.complete = 1'b1;
          state_next.prescale = '0;
          state_next.ms_cnt   = '0;
        end
      end
      ST_HOLD: begin
        if (state_reg.ms_cnt >= torque_switch_delay_param) begin
          state_next.torque = stop_torque_limit_param; // [RULE_12]
          state_next.st     = ST_DONE;
        end else if (state_reg.prescale == PRE_LAST) begin
          state_next.prescale = '0;
          state_next.ms_cnt   = state_reg.ms_cnt + DELAY_W'(1);
        end else begin
          state_next.prescale = state_reg.prescale + PRE_W'(1);
        end
      end
      default: begin
        state_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg    <= '0;
      state_reg.st <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign in_position           = state_reg.in_pos;
  assign move_complete         = state_reg.complete;
  assign home_missing_alarm    = state_reg.home_alarm;
  assign station_range_warning = state_reg.range_warn;
  assign torque_limit          = state_reg.torque;
  assign move_req              = state_reg.req;
  assign move_station          = state_reg.station;
  assign move_speed            = state_reg.speed;
  assign move_accel            = state_reg.accel;
  assign move_decel            = state_reg.decel;
  assign move_dir_fwd          = state_reg.dir_fwd;

endmodule : indexer_station_positioning

// file: test/indexer_checker.sv
`timescale 1ns/100ps
module indexer_checker
  import indexer_pkg::*;
#(
  parameter int unsigned MS_CYCLES_P = 4
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        start_cmd,
  input wire logic        home_done,
  input wire logic [3:0]  operation_select_param,
  input wire logic [15:0] run_torque_limit,
  input wire logic [15:0] stop_torque_limit_param,
  input wire logic [15:0] torque_switch_delay_param,
  input wire logic        pos_in_range,
  input wire logic        motion_done,
  input wire logic        move_req,
  input wire logic        in_position,
  input wire logic        move_complete,
  input wire logic        home_missing_alarm,
  input wire logic [15:0] torque_limit,
  input wire logic [7:0]  move_station,
  input wire logic [15:0] move_speed
);
  logic        prev_reg;
  logic        mv_reg;
  logic        seen_reg;
  logic [31:0] hold_reg;
  logic        rise;
  logic [31:0] due;
  // The start history resets high so a start held through reset never counts as an edge.
  assign rise = start_cmd && !prev_reg;
  // The stop limit shows one cycle after the last whole millisecond of the delay has been counted.
  assign due = 32'(torque_switch_delay_param) * MS_CYCLES_P + 32'h1;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_reg <= 1'b1;
      mv_reg   <= 1'b0;
      seen_reg <= 1'b0;
      hold_reg <= 32'h0;
    end else begin
      prev_reg <= start_cmd;
      seen_reg <= seen_reg | move_req;
      mv_reg   <= move_req | (mv_reg & !move_complete);
      hold_reg <= move_complete ? hold_reg + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_req_pulse; move_req |=> !move_req; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("move request held too long");
  property p_home_gate; move_req |-> $past(home_done); endproperty
  a_home_gate: assert property (p_home_gate) else $error("move issued without home");
  property p_alarm;
    rise && !mv_reg && !move_complete && operation_select_param == OPSEL_INDEXER && !home_done
      |=> home_missing_alarm && !move_req;
  endproperty
  a_alarm: assert property (p_alarm) else $error("home alarm missing");
  property p_ignore; rise && mv_reg |=> !move_req; endproperty
  a_ignore: assert property (p_ignore) else $error("start accepted during move");
  property p_hold_cmd; $past(rst_n) && !move_req |-> $stable(move_station) && $stable(move_speed); endproperty
  a_hold_cmd: assert property (p_hold_cmd) else $error("move command changed");
  property p_done; mv_reg && !move_complete && !move_req && motion_done |=> in_position && move_complete; endproperty
  a_done: assert property (p_done) else $error("completion not reported");
  property p_inpos_idle; $past(rst_n) && !seen_reg && !move_req |-> in_position == $past(pos_in_range); endproperty
  a_inpos_idle: assert property (p_inpos_idle) else $error("idle in-position wrong");
  property p_torque_run; move_req |-> torque_limit == $past(run_torque_limit); endproperty
  a_torque_run: assert property (p_torque_run) else $error("run torque not loaded");
  property p_torque_early; move_complete && hold_reg + 32'h1 == due |-> torque_limit != stop_torque_limit_param; endproperty
  a_torque_early: assert property (p_torque_early) else $error("stop torque too early");
  property p_torque_stop; move_complete && hold_reg == due |-> torque_limit == stop_torque_limit_param; endproperty
  a_torque_stop: assert property (p_torque_stop) else $error("stop torque late");
endmodule : indexer_checker

bind indexer_station_positioning indexer_checker #(.MS_CYCLES_P(MS_CYCLES_P)) u_indexer_checker (
  .clk, .rst_n, .start_cmd, .home_done, .operation_select_param, .run_torque_limit, .stop_torque_limit_param,
  .torque_switch_delay_param, .pos_in_range, .motion_done, .move_req, .in_position, .move_complete,
  .home_missing_alarm, .torque_limit, .move_station, .move_speed);

// file: test/motion_model.sv
`timescale 1ns/100ps
module motion_model (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       move_req,
  input wire logic [7:0] lat,
  output logic           motion_done,
  output logic           pos_in_range
);
  logic [7:0] cnt_reg;
  logic       run_reg;
  // The axis is parked at a station when power comes up, so the range flag starts high.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {run_reg, motion_done, cnt_reg} <= '0;
      pos_in_range <= 1'b1;
    end else if (move_req) begin
      {run_reg, cnt_reg, motion_done, pos_in_range} <= {1'b1, lat, 2'b00};
    end else if (run_reg && cnt_reg == 8'h00) begin
      {run_reg, motion_done, pos_in_range} <= 3'b011;
    end else begin
      cnt_reg <= cnt_reg - 8'(run_reg);
      motion_done <= 1'b0;
    end
  end
endmodule : motion_model

// file: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import indexer_pkg::*;
  logic clk, rst_n, table_wr_en, station_direction_param, two_station_mode, opmode_sel_a, opmode_sel_b;
  logic position_speed_spec_sel, start_cmd, rotation_dir_cmd, home_done, alarm_clear, pos_in_range;
  logic motion_done, in_position, move_complete, home_missing_alarm, station_range_warning, move_req, move_dir_fwd;
  logic [2:0]  table_wr_idx, speed_sel_bits;
  logic [15:0] table_wr_speed, speed_or_table_word, move_speed, torque_limit, run_torque_limit;
  logic [15:0] stop_torque_limit_param, torque_switch_delay_param;
  logic [14:0] table_wr_accel, table_wr_decel, move_accel, move_decel;
  logic [3:0]  operation_select_param, speed_source_param;
  logic [7:0]  station_count_param, target_station_word, station_sel_bits, current_station, move_station, lat;
  logic [15:0] spd [8];
  logic [14:0] acc [8];
  logic [14:0] dcl [8];
  logic [7:0]  sh [4] = '{8'h04, 8'h06, 8'h05, 8'h00};
  int          failures, check_count;

  indexer_station_positioning #(.MS_CYCLES_P(4)) u_indexer_station_positioning (
    .clk, .rst_n, .table_wr_en, .table_wr_idx, .table_wr_speed, .table_wr_accel, .table_wr_decel,
    .operation_select_param, .speed_source_param, .station_count_param, .station_direction_param,
    .stop_torque_limit_param, .torque_switch_delay_param, .run_torque_limit, .two_station_mode,
    .opmode_sel_a, .opmode_sel_b, .position_speed_spec_sel, .start_cmd, .rotation_dir_cmd,
    .target_station_word, .speed_or_table_word, .station_sel_bits, .speed_sel_bits, .home_done,
    .alarm_clear, .pos_in_range, .current_station, .motion_done, .in_position, .move_complete,
    .home_missing_alarm, .station_range_warning, .torque_limit, .move_req, .move_station,
    .move_speed, .move_accel, .move_decel, .move_dir_fwd);
  motion_model u_motion_model (.clk, .rst_n, .move_req, .lat, .motion_done, .pos_in_range);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic wait_hi(input bit done_sel, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((done_sel ? move_complete : move_req) !== 1'b1 && n < lim);
  endtask : wait_hi

  // A second start is raised mid-move with scrambled words; the move must keep its latched command.
  task automatic run_move(input logic [7:0] stn, input logic [15:0] word, input logic [15:0] e_spd,
                          input logic [14:0] e_acc, input logic [14:0] e_dec, input logic e_dir);
    int n;
    @(posedge clk);
    {target_station_word, station_sel_bits, speed_or_table_word} <= {stn, stn, word};
    @(posedge clk);
    start_cmd <= 1'b1;
    wait_hi(1'b0, 20);
    chk(32'(move_station), 32'(stn));
    chk(32'(move_speed), 32'(e_spd));
    chk(32'(move_accel), 32'(e_acc));
    chk(32'(move_decel), 32'(e_dec));
    chk(32'(move_dir_fwd), 32'(e_dir));
    chk(32'(torque_limit), 32'h0100);
    @(posedge clk);
    start_cmd <= 1'b0;
    {target_station_word, station_sel_bits, speed_or_table_word} <= ~{stn, stn, word};
    @(posedge clk);
    start_cmd <= 1'b1;
    @(posedge clk);
    start_cmd <= 1'b0;
    wait_hi(1'b1, 300);
    chk(32'(in_position), 32'h1);
    chk(32'({move_station, move_speed}), 32'({stn, e_spd}));
    n = 0;
    while (torque_limit !== 16'h0040 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(torque_limit), 32'h0040);
  endtask : run_move

  initial begin
    {rst_n, table_wr_en, station_direction_param, opmode_sel_a, start_cmd, rotation_dir_cmd, home_done} = '0;
    {alarm_clear, table_wr_idx, speed_sel_bits, table_wr_speed, table_wr_accel, table_wr_decel} = '0;
    {target_station_word, speed_or_table_word, station_sel_bits, current_station, failures, check_count} = '0;
    {opmode_sel_b, position_speed_spec_sel, two_station_mode, lat} = {3'b111, 8'h05};
    {operation_select_param, speed_source_param, station_count_param} = {OPSEL_INDEXER, SPEED_SRC_TABLE, 8'h08};
    {stop_torque_limit_param, torque_switch_delay_param, run_torque_limit} = {16'h0040, 16'h0002, 16'h0100};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(32'({move_req, home_missing_alarm, in_position}), 32'h1);
    for (int i = 0; i < 8; i++) begin
      spd[i] = 16'h0100 + 16'(i);
      acc[i] = (i == 7) ? 15'h7FFF : 15'(i * 100);
      dcl[i] = (i == 7) ? 15'h4E21 : 15'(i * 100 + 7);
      @(posedge clk);
      {table_wr_en, table_wr_idx, table_wr_speed, table_wr_accel, table_wr_decel} <= {1'b1, 3'(i), spd[i], acc[i], dcl[i]};
      acc[i] = (acc[i] > TC_MAX_MS) ? TC_MAX_MS : acc[i];
      dcl[i] = (dcl[i] > TC_MAX_MS) ? TC_MAX_MS : dcl[i];
    end
    @(posedge clk);
    {table_wr_en, start_cmd} <= 2'b01;
    repeat (4) @(posedge clk);
    #1;
    chk(32'({home_missing_alarm, in_position}), 32'h3);
    @(posedge clk);
    {start_cmd, alarm_clear, home_done} <= 3'b011;
    @(posedge clk);
    alarm_clear <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(32'(home_missing_alarm), 32'h0);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {lat, rotation_dir_cmd} <= {8'(5 + i), i[0]};
      run_move(8'(i), 16'(i), spd[i], acc[i], dcl[i], i[0]);
    end
    @(posedge clk);
    {two_station_mode, speed_source_param} <= {1'b0, SPEED_SRC_DIRECT};
    run_move(8'h02, 16'h0005, spd[0], acc[0], dcl[0], 1'b1);
    @(posedge clk);
    {two_station_mode, station_direction_param} <= 2'b11;
    run_move(8'h03, 16'h0BB8, 16'h0BB8, acc[0], dcl[0], 1'b0);
    @(posedge clk);
    {speed_source_param, target_station_word} <= {SPEED_SRC_TABLE, 8'h07};
    repeat (3) @(posedge clk);
    #1;
    chk(32'(station_range_warning), 32'h0);
    @(posedge clk);
    {target_station_word, start_cmd} <= {8'h08, 1'b1};
    repeat (4) @(posedge clk);
    #1;
    chk(32'({station_range_warning, move_complete, move_station}), 32'h303);
    @(posedge clk);
    {start_cmd, opmode_sel_a, speed_sel_bits, current_station} <= {2'b01, 3'h3, 8'h01};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      station_direction_param <= k[0];
      run_move(sh[k], 16'h0006, spd[3], acc[3], dcl[3], ((sh[k] + 8'h07) % 8'h08) * 2 <= 8'h08);
    end
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule : tb_top
